// ### shared/qu_pkg.sv
// qu_pkg: constants shared by the quad uart host port, serial engine and channel logic
// assumes one 250 MHz core clock and a synchronous active-high reset
package qu_pkg;
  // ==========================================================
  // sizes
  localparam int QU_NUM_CH = 4;
  localparam int QU_DATA_W = 8;
  localparam int QU_ADDR_W = 3;
  // ==========================================================
  // register offsets on the three address bits
  localparam logic [2:0] QU_OFS_DATA = 3'h0;
  localparam logic [2:0] QU_OFS_IEN = 3'h1;
  localparam logic [2:0] QU_OFS_ISTAT = 3'h2;
  localparam logic [2:0] QU_OFS_EFR = 3'h3;
  localparam logic [2:0] QU_OFS_MCR = 3'h4;
  localparam logic [2:0] QU_OFS_LSTAT = 3'h5;
  localparam logic [2:0] QU_OFS_MSTAT = 3'h6;
  localparam logic [2:0] QU_OFS_DIV = 3'h7;
  // ==========================================================
  // field positions
  localparam int QU_MCR_DTR = 0;
  localparam int QU_MCR_RTS = 1;
  localparam int QU_MCR_IRQEN = 3;
  localparam int QU_MCR_LOOP = 4;
  localparam int QU_EFR_ARTS = 6;
  localparam int QU_EFR_ACTS = 7;
  localparam int QU_MSR_CTS = 4;
  localparam int QU_IS_RXERR = 0;
  localparam int QU_IS_RXDATA = 1;
  localparam int QU_IS_TXEMPTY = 2;
  localparam int QU_IS_MODEM = 3;
  // ==========================================================
  // reset values
  localparam logic [7:0] QU_IEN_RST = 8'h00;
  localparam logic [7:0] QU_EFR_RST = 8'h00;
  localparam logic [7:0] QU_MCR_RST = 8'h00;
  localparam logic [7:0] QU_DIV_RST = 8'h01;
  // ==========================================================
  // timing: core ticks per bit are div * oversample
  localparam logic [3:0] QU_OVS_LAST = 4'hF;
  localparam logic [3:0] QU_OVS_MID = 4'h7;
endpackage : qu_pkg

// ### hdl/qu_host_port.sv
// qu_host_port: turns the asynchronous-style host strobes into per-channel pulses
// assumes strobes, selects and address are already synchronous to core_clk
`timescale 1ns/1ns
module qu_host_port
  import qu_pkg::*;
#(
  parameter int NCH = QU_NUM_CH
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host pins
  input wire logic [NCH-1:0] channel_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  // per-channel access
  output logic [NCH-1:0] wr_stb,
  output logic [NCH-1:0] rd_on,
  output logic [NCH-1:0] rd_done,
  output logic [2:0] addr_q,
  output logic [7:0] wdata_q
);
  typedef struct packed {
    logic wr_n_q;
    logic [NCH-1:0] wr;
    logic [NCH-1:0] rd;
    logic [NCH-1:0] done;
    logic [2:0] a;
    logic [7:0] d;
  } qu_port_t;
  qu_port_t s_ff, nxt_s;
  logic [NCH-1:0] sel;

  // ==========================================================
  // strobe decode
  always_comb
  begin
    sel = ~channel_select_n; // RULE1
    nxt_s = s_ff;
    nxt_s.wr_n_q = write_strobe_n;
    // one write per strobe, taken on its first low cycle
    nxt_s.wr = (write_strobe_n || !s_ff.wr_n_q) ? '0 : sel; // RULE3
    nxt_s.rd = read_strobe_n ? '0 : sel; // RULE2
    nxt_s.done = s_ff.rd & ~nxt_s.rd;
    nxt_s.a = addr;
    nxt_s.d = data_in;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.wr_n_q <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign wr_stb = s_ff.wr;
  assign rd_on = s_ff.rd;
  assign rd_done = s_ff.done;
  assign addr_q = s_ff.a;
  assign wdata_q = s_ff.d;
endmodule : qu_host_port

// ### hdl/qu_serial.sv
// qu_serial: one 8N1 transmitter and receiver with 16x oversampling
// assumes rx_in is synchronous to core_clk; tx_req is held until tx_take
`timescale 1ns/1ns
module qu_serial
  import qu_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic [7:0] div,
  input wire logic tx_req,
  input wire logic [7:0] tx_data,
  input wire logic cts_ok,
  input wire logic rx_in,
  // results
  output logic tx_out,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_stb,
  output logic rx_ferr
);
  typedef struct packed {
    logic [7:0] dcnt;
    logic tx_on;
    logic [9:0] tx_sh;
    logic [3:0] tx_ph;
    logic [3:0] tx_bit;
    logic tx;
    logic take;
    logic rx_on;
    logic [3:0] rx_ph;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_d;
    logic stb;
    logic ferr;
  } qu_ser_t;
  qu_ser_t s_ff, nxt_s;
  logic tick;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.take = 1'b0;
    nxt_s.stb = 1'b0;
    nxt_s.ferr = 1'b0;
    tick = (s_ff.dcnt == 8'h00);
    nxt_s.dcnt = tick ? ((div == 8'h00) ? 8'h00 : div - 8'h01) : s_ff.dcnt - 8'h01;
    // ==========================================================
    // transmitter, bit 0 of the character leaves first
    if (!s_ff.tx_on)
    begin
      if (tx_req && cts_ok) // RULE6
      begin
        nxt_s.tx_on = 1'b1;
        nxt_s.tx_sh = {1'b1, tx_data, 1'b0}; // RULE4
        nxt_s.tx_ph = 4'h0;
        nxt_s.tx_bit = 4'h0;
        nxt_s.take = 1'b1;
      end
    end
    else if (tick)
    begin
      nxt_s.tx_ph = s_ff.tx_ph + 4'h1;
      if (s_ff.tx_ph == QU_OVS_LAST)
      begin
        nxt_s.tx_sh = {1'b1, s_ff.tx_sh[9:1]};
        nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
        if (s_ff.tx_bit == 4'h9)
          nxt_s.tx_on = 1'b0;
      end
    end
    nxt_s.tx = nxt_s.tx_on ? nxt_s.tx_sh[0] : 1'b1;
    // ==========================================================
    // receiver, start bit checked at mid-bit
    if (!s_ff.rx_on)
    begin
      if (!rx_in)
      begin
        nxt_s.rx_on = 1'b1;
        nxt_s.rx_ph = 4'h0;
        nxt_s.rx_bit = 4'h0;
      end
    end
    else if (tick)
    begin
      nxt_s.rx_ph = s_ff.rx_ph + 4'h1;
      if (s_ff.rx_ph == ((s_ff.rx_bit == 4'h0) ? QU_OVS_MID : QU_OVS_LAST))
      begin
        nxt_s.rx_ph = 4'h0;
        nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
        if (s_ff.rx_bit == 4'h0)
          nxt_s.rx_on = !rx_in;
        else if (s_ff.rx_bit == 4'h9)
        begin
          nxt_s.rx_on = 1'b0;
          nxt_s.rx_d = s_ff.rx_sh;
          nxt_s.stb = rx_in;
          nxt_s.ferr = !rx_in;
        end
        else
          nxt_s.rx_sh = {rx_in, s_ff.rx_sh[7:1]}; // RULE4
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.tx <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign tx_out = s_ff.tx;
  assign tx_take = s_ff.take;
  assign rx_data = s_ff.rx_d;
  assign rx_stb = s_ff.stb;
  assign rx_ferr = s_ff.ferr;
endmodule : qu_serial

// ### hdl/qu_uart.sv
// qu_uart: quad uart channel registers, modem pins, interrupts and combined dma ready
// assumes all pins synchronous to core_clk; interrupt and data pins resolved outside
//
// Behaviour
// RULE1: a channel answers strobes only while its active-low select is low.
// RULE2: read strobe low drives the addressed channel register onto the data bus.
// RULE3: write strobe low stores the data bus into the addressed register.
// RULE4: data bit 0 is the first serial bit sent and received.
// RULE5: modem status bit 4 shows the clear-to-send input.
// RULE6: clear-to-send holds transmission only when auto-cts feature bit 7 is set.
// RULE7: dtr output low when modem control bit 0 is one; high after reset.
// RULE8: channel interrupt high only with bit 3 or force select, enable and a pending condition.
// RULE9: interrupt outputs are high impedance after reset.
// RULE10: force-select input high drives interrupts continuously, ignoring bit 3.
// RULE11: reset clears registers and outputs and idles transmitter and receiver.
// RULE12: rising ring-indicator input raises an enabled modem status interrupt.
// RULE13: rts output low when modem control bit 1 is one; high after reset.
// RULE14: rts joins flow control only when auto-rts feature bit 6 is set.
// RULE15: loopback disconnects the receive pin and feeds transmit data to receiver.
// RULE16: combined rx ready low while any channel holds data, high when all empty.
// RULE17: combined tx ready low while any channel has room, high when all full.
// RULE18: host holds address and select during a strobe, one strobe at a time.
`timescale 1ns/1ns
module qu_uart
  import qu_pkg::*;
#(
  parameter int NCH = QU_NUM_CH
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host bus
  input wire logic [NCH-1:0] channel_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // serial lines
  output logic [NCH-1:0] tx,
  input wire logic [NCH-1:0] rx,
  // modem pins
  input wire logic [NCH-1:0] cts_n,
  input wire logic [NCH-1:0] dsr_n,
  input wire logic [NCH-1:0] dcd_n,
  input wire logic [NCH-1:0] ri_n,
  output logic [NCH-1:0] rts_n,
  output logic [NCH-1:0] dtr_n,
  // interrupts
  input wire logic irq_force_select,
  output logic [NCH-1:0] channel_irq,
  output logic [NCH-1:0] channel_irq_oe_n,
  // dma ready
  output logic rx_ready_n,
  output logic tx_ready_n
);
  // ==========================================================
  // parameter check
  if (NCH < 1 || NCH > 8)
  begin : g_bad_nch
    $error("qu_uart: NCH must be 1 to 8");
  end

  typedef struct packed {
    logic [7:0] ien;
    logic [3:0] istat;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] div;
    logic [7:0] thr;
    logic thr_full;
    logic [7:0] rhr;
    logic rhr_full;
    logic overrun;
    logic ferr;
    logic [3:0] mdelta;
    logic cts_q;
    logic dsr_q;
    logic dcd_q;
    logic ri_q;
    logic rts_n;
    logic dtr_n;
    logic irq;
    logic irq_oe_n;
    logic tx;
  } qu_chan_t;

  typedef struct packed {
    logic [7:0] dout;
    logic doe_n;
    logic rxr_n;
    logic txr_n;
  } qu_top_t;

  // ==========================================================
  // host port
  logic [NCH-1:0] wr_stb;
  logic [NCH-1:0] rd_on;
  logic [NCH-1:0] rd_done;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic [NCH-1:0][7:0] rd_val;
  logic [NCH-1:0] rx_full;
  logic [NCH-1:0] tx_full;

  qu_host_port #(
    .NCH(NCH)
  ) u_port (
    .core_clk(core_clk),
    .reset(reset),
    .channel_select_n(channel_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .addr(addr),
    .data_in(data_in),
    .wr_stb(wr_stb),
    .rd_on(rd_on),
    .rd_done(rd_done),
    .addr_q(addr_q),
    .wdata_q(wdata_q)
  );

  // ==========================================================
  // channels
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    qu_chan_t s_ff, nxt_s;
    logic ser_tx;
    logic tx_take;
    logic [7:0] rx_byte;
    logic rx_stb;
    logic rx_ferr;
    logic ser_rx;
    logic cts_ok;
    logic [7:0] modem_status_reg;
    logic [7:0] lsr;
    logic [3:0] ev;
    logic drive;

    // loopback feeds the transmitter back and ignores the pin
    assign ser_rx = s_ff.modem_control_reg[QU_MCR_LOOP] ? ser_tx : rx[c]; // RULE15
    assign cts_ok = !s_ff.enhanced_feature_reg[QU_EFR_ACTS] || !cts_n[c]; // RULE6
    assign modem_status_reg = {~dcd_n[c], ~ri_n[c], ~dsr_n[c], ~cts_n[c], s_ff.mdelta}; // RULE5
    assign lsr = {1'b0, !s_ff.thr_full && s_ff.tx == 1'b1, !s_ff.thr_full,
                  3'h0, s_ff.ferr || s_ff.overrun, s_ff.rhr_full};

    qu_serial u_ser (
      .core_clk(core_clk),
      .reset(reset),
      .div(s_ff.div),
      .tx_req(s_ff.thr_full),
      .tx_data(s_ff.thr),
      .cts_ok(cts_ok),
      .rx_in(ser_rx),
      .tx_out(ser_tx),
      .tx_take(tx_take),
      .rx_data(rx_byte),
      .rx_stb(rx_stb),
      .rx_ferr(rx_ferr)
    );

    // ==========================================================
    // register read mux
    always_comb
    begin
      case (addr_q)
        QU_OFS_DATA: rd_val[c] = s_ff.rhr;
        QU_OFS_IEN: rd_val[c] = s_ff.ien;
        QU_OFS_ISTAT: rd_val[c] = {4'h0, s_ff.istat};
        QU_OFS_EFR: rd_val[c] = s_ff.enhanced_feature_reg;
        QU_OFS_MCR: rd_val[c] = s_ff.modem_control_reg;
        QU_OFS_LSTAT: rd_val[c] = lsr;
        QU_OFS_MSTAT: rd_val[c] = modem_status_reg;
        QU_OFS_DIV: rd_val[c] = s_ff.div;
        default: rd_val[c] = 8'h00;
      endcase
    end

    // ==========================================================
    // channel state
    always_comb
    begin
      nxt_s = s_ff;
      ev = 4'h0;
      nxt_s.cts_q = cts_n[c];
      nxt_s.dsr_q = dsr_n[c];
      nxt_s.dcd_q = dcd_n[c];
      nxt_s.ri_q = ri_n[c];
      // reads that consume state, at the end of the strobe
      if (rd_done[c] && addr_q == QU_OFS_DATA)
        nxt_s.rhr_full = 1'b0;
      if (rd_done[c] && addr_q == QU_OFS_MSTAT)
        nxt_s.mdelta = 4'h0;
      if (rd_done[c] && addr_q == QU_OFS_LSTAT)
      begin
        nxt_s.overrun = 1'b0;
        nxt_s.ferr = 1'b0;
      end
      if (tx_take)
        nxt_s.thr_full = 1'b0;
      // writes
      if (wr_stb[c]) // RULE3
      begin
        case (addr_q)
          QU_OFS_DATA:
          begin
            nxt_s.thr = wdata_q;
            nxt_s.thr_full = 1'b1;
          end
          QU_OFS_IEN: nxt_s.ien = wdata_q;
          QU_OFS_ISTAT: nxt_s.istat = s_ff.istat & ~wdata_q[3:0];
          QU_OFS_EFR: nxt_s.enhanced_feature_reg = wdata_q;
          QU_OFS_MCR: nxt_s.modem_control_reg = wdata_q;
          QU_OFS_DIV: nxt_s.div = wdata_q;
          default: nxt_s.div = s_ff.div;
        endcase
      end
      // receive path, a byte landing on unread data is an overrun
      if (rx_stb)
      begin
        nxt_s.rhr = rx_byte;
        nxt_s.rhr_full = 1'b1;
        nxt_s.overrun = s_ff.rhr_full ? 1'b1 : nxt_s.overrun;
        ev[QU_IS_RXDATA] = 1'b1;
        ev[QU_IS_RXERR] = s_ff.rhr_full;
      end
      if (rx_ferr)
      begin
        nxt_s.ferr = 1'b1;
        ev[QU_IS_RXERR] = 1'b1;
      end
      ev[QU_IS_TXEMPTY] = tx_take;
      // modem deltas; ring counts only on its trailing edge
      if (cts_n[c] != s_ff.cts_q)
        nxt_s.mdelta[0] = 1'b1;
      if (dsr_n[c] != s_ff.dsr_q)
        nxt_s.mdelta[1] = 1'b1;
      if (ri_n[c] && !s_ff.ri_q) // RULE12
        nxt_s.mdelta[2] = 1'b1;
      if (dcd_n[c] != s_ff.dcd_q)
        nxt_s.mdelta[3] = 1'b1;
      ev[QU_IS_MODEM] = (cts_n[c] != s_ff.cts_q) || (dsr_n[c] != s_ff.dsr_q)
                        || (ri_n[c] && !s_ff.ri_q) || (dcd_n[c] != s_ff.dcd_q); // RULE12
      // events win over a same-cycle write-one clear
      nxt_s.istat = nxt_s.istat | ev;
      // ==========================================================
      // pins
      nxt_s.dtr_n = !nxt_s.modem_control_reg[QU_MCR_DTR]; // RULE7
      nxt_s.rts_n = !(nxt_s.modem_control_reg[QU_MCR_RTS]
                      && (!nxt_s.enhanced_feature_reg[QU_EFR_ARTS] || !nxt_s.rhr_full)); // RULE13 RULE14
      drive = nxt_s.modem_control_reg[QU_MCR_IRQEN] || irq_force_select; // RULE10
      nxt_s.irq = drive && |(nxt_s.istat & nxt_s.ien[3:0]); // RULE8
      nxt_s.irq_oe_n = !drive; // RULE9
      nxt_s.tx = nxt_s.modem_control_reg[QU_MCR_LOOP] ? 1'b1 : ser_tx; // RULE15
    end

    always_ff @(posedge core_clk)
    begin
      if (reset) // RULE11
      begin
        s_ff <= '0;
        s_ff.ien <= QU_IEN_RST;
        s_ff.enhanced_feature_reg <= QU_EFR_RST;
        s_ff.modem_control_reg <= QU_MCR_RST;
        s_ff.div <= QU_DIV_RST;
        s_ff.cts_q <= 1'b1;
        s_ff.dsr_q <= 1'b1;
        s_ff.dcd_q <= 1'b1;
        s_ff.ri_q <= 1'b1;
        s_ff.rts_n <= 1'b1; // RULE13
        s_ff.dtr_n <= 1'b1; // RULE7
        s_ff.irq_oe_n <= 1'b1; // RULE9
        s_ff.tx <= 1'b1;
      end
      else
        s_ff <= nxt_s;
    end

    assign tx[c] = s_ff.tx;
    assign rts_n[c] = s_ff.rts_n;
    assign dtr_n[c] = s_ff.dtr_n;
    assign channel_irq[c] = s_ff.irq;
    assign channel_irq_oe_n[c] = s_ff.irq_oe_n;
    assign rx_full[c] = s_ff.rhr_full;
    assign tx_full[c] = s_ff.thr_full;
  end

  // ==========================================================
  // shared data bus and dma ready
  qu_top_t t_ff, nxt_t;

  always_comb
  begin
    nxt_t = t_ff;
    nxt_t.dout = 8'h00;
    for (int i = 0; i < NCH; i++)
    begin
      if (rd_on[i]) // RULE2
        nxt_t.dout = nxt_t.dout | rd_val[i];
    end
    nxt_t.doe_n = !(|rd_on);
    nxt_t.rxr_n = !(|rx_full); // RULE16
    nxt_t.txr_n = &tx_full; // RULE17
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      t_ff <= '0;
      t_ff.doe_n <= 1'b1;
      t_ff.rxr_n <= 1'b1;
      t_ff.txr_n <= 1'b0;
    end
    else
      t_ff <= nxt_t;
  end

  assign data_out = t_ff.dout;
  assign data_oe_n = t_ff.doe_n;
  assign rx_ready_n = t_ff.rxr_n;
  assign tx_ready_n = t_ff.txr_n;
endmodule : qu_uart

// ### bench/qu_uart_props.sv
// qu_uart_props: port-level checks for the quad uart
// assumes the qu_uart top ports and a single core clock with synchronous reset
`timescale 1ns/1ns
module qu_uart_props
  import qu_pkg::*;
#(
  parameter int NCH = QU_NUM_CH
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host bus
  input wire logic [NCH-1:0] channel_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  // pins
  input wire logic [NCH-1:0] tx,
  input wire logic [NCH-1:0] rts_n,
  input wire logic [NCH-1:0] dtr_n,
  input wire logic irq_force_select,
  input wire logic [NCH-1:0] channel_irq,
  input wire logic [NCH-1:0] channel_irq_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // sequences
  sequence s_read_held;
    !read_strobe_n && !(&channel_select_n);
  endsequence
  sequence s_mcr_write;
    $fell(write_strobe_n) && !channel_select_n[0] && addr == QU_OFS_MCR;
  endsequence
  // ==========================================================
  // assertions
  a_reset_pins: assert property (disable iff (1'b0) reset |=>
    &dtr_n && &rts_n && &tx && &channel_irq_oe_n && data_oe_n && channel_irq == '0)
    else $error("outputs not idle after reset");
  a_irq_gate: assert property ((channel_irq & channel_irq_oe_n) == '0)
    else $error("interrupt high while output not driven");
  a_force_drive: assert property (irq_force_select[*3] |-> channel_irq_oe_n == '0)
    else $error("force select did not drive interrupts");
  a_quiet_bus: assert property ((&channel_select_n)[*4] |=> data_oe_n)
    else $error("data bus driven with no channel selected");
  a_read_drive: assert property (s_read_held |-> ##2 !data_oe_n)
    else $error("read strobe did not drive data bus");
  a_read_release: assert property (read_strobe_n[*3] |=> data_oe_n)
    else $error("data bus held after read strobe ended");
  a_idle_zero: assert property (data_oe_n |-> data_out == 8'h00)
    else $error("read data not zero while bus released");
  a_dtr_write: assert property (s_mcr_write |-> ##4 (dtr_n[0] == !$past(data_in[0], 4)))
    else $error("dtr does not follow modem control write");
  a_rts_write: assert property (s_mcr_write |-> ##4 (rts_n[0] == !$past(data_in[1], 4)))
    else $error("rts does not follow modem control write");
endmodule : qu_uart_props

bind qu_uart qu_uart_props #(.NCH(NCH)) u_props (.core_clk(core_clk), .reset(reset),
  .channel_select_n(channel_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .tx(tx), .rts_n(rts_n),
  .dtr_n(dtr_n), .irq_force_select(irq_force_select), .channel_irq(channel_irq),
  .channel_irq_oe_n(channel_irq_oe_n));

// ### bench/qu_host_model.sv
// qu_host_model: host cpu on the register bus, one access at a time
// assumes core_clk; changes pins right after a rising edge
`timescale 1ns/1ns
module qu_host_model
  import qu_pkg::*;
(
  // clock
  input wire logic core_clk,
  // host bus
  output logic [QU_NUM_CH-1:0] channel_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] addr,
  output logic [7:0] data_in,
  // answer
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  initial
  begin
    channel_select_n = '1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
  end
  // ==========================================================
  // write: one strobe cycle, select held one more
  task wr(input logic [3:0] sel, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    channel_select_n <= sel;
    addr <= a;
    data_in <= d;
    write_strobe_n <= 1'b0;
    @(posedge core_clk);
    write_strobe_n <= 1'b1;
    @(posedge core_clk);
    channel_select_n <= '1;
    data_in <= ~d;
    repeat (3) @(posedge core_clk);
  endtask : wr
  // ==========================================================
  // read: one strobe cycle, data taken at the edge where the bus shows driven
  task rd(input logic [3:0] sel, input logic [2:0] a, output logic [7:0] d);
    int n;
    @(posedge core_clk);
    channel_select_n <= sel;
    addr <= a;
    read_strobe_n <= 1'b0;
    @(posedge core_clk);
    read_strobe_n <= 1'b1;
    for (n = 0; n < 8; n++)
    begin
      @(posedge core_clk);
      if (data_oe_n === 1'b0)
        break;
    end
    d = data_out;
    repeat (3) @(posedge core_clk);
    channel_select_n <= '1;
  endtask : rd
endmodule : qu_host_model

// ### bench/uart_host_port_and_modem_pins_test.sv
// uart_host_port_and_modem_pins_test: self-checking bench for qu_uart
// assumes 250 MHz core clock, divisor left at reset value
`timescale 1ns/1ns
module uart_host_port_and_modem_pins_test;
  import qu_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] channel_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, b, v;
  logic data_oe_n, rx_ready_n, tx_ready_n, lb;
  logic irq_force_select = 1'b0;
  logic [3:0] rx = 4'hF, cts_n = 4'h0, ri_n = 4'hF, ed, er;
  logic [3:0] tx, rts_n, dtr_n, channel_irq, channel_irq_oe_n;
  logic [7:0] mcr_m [4];
  logic [7:0] rxq [$];
  int errors = 0, checked = 0, c, n;
  // ==========================================================
  // design, host and clock
  qu_host_model host (.core_clk(core_clk), .channel_select_n(channel_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
  qu_uart DUT (.core_clk(core_clk), .reset(reset), .channel_select_n(channel_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .tx(tx), .rx(rx), .cts_n(cts_n), .dsr_n(4'hF),
    .dcd_n(4'hF), .ri_n(ri_n), .rts_n(rts_n), .dtr_n(dtr_n), .irq_force_select(irq_force_select),
    .channel_irq(channel_irq), .channel_irq_oe_n(channel_irq_oe_n), .rx_ready_n(rx_ready_n),
    .tx_ready_n(tx_ready_n));
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  // ==========================================================
  // checking and closing
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk
  task end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #(30000 * 4);
    errors++;
    end_of_test();
  end
  // ==========================================================
  // tests
  initial
  begin
    void'($urandom(45201));
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk("dtr_n", 8'h0F, {4'h0, dtr_n});
    chk("rts_n", 8'h0F, {4'h0, rts_n});
    chk("irq_oe_n", 8'h0F, {4'h0, channel_irq_oe_n});
    chk("tx", 8'h0F, {4'h0, tx});
    // strobes with no channel selected
    host.wr(4'hF, QU_OFS_MCR, 8'h03);
    chk("dtr_n", 8'h0F, {4'h0, dtr_n});
    for (c = 0; c < 4; c++)
    begin
      mcr_m[c] = 8'(c);
      host.wr(~(4'h1 << c), QU_OFS_MCR, mcr_m[c]);
      host.rd(~(4'h1 << c), QU_OFS_MCR, v);
      chk("mcr", mcr_m[c], v);
      ed[c] = !mcr_m[c][QU_MCR_DTR];
      er[c] = !mcr_m[c][QU_MCR_RTS];
    end
    chk("dtr_n", {4'h0, ed}, {4'h0, dtr_n});
    chk("rts_n", {4'h0, er}, {4'h0, rts_n});
    host.wr(4'h7, QU_OFS_MCR, 8'h00);
    chk("dtr_n3", 8'h01, {7'h0, dtr_n[3]});
    // clear-to-send shown in modem status
    cts_n <= 4'($urandom);
    repeat (4) @(posedge core_clk);
    for (c = 0; c < 4; c++)
    begin
      host.rd(~(4'h1 << c), QU_OFS_MSTAT, v);
      chk("cts", {7'h0, ~cts_n[c]}, {7'h0, v[QU_MSR_CTS]});
    end
    // transmit with clear-to-send inactive and auto-cts off, lsb first
    cts_n[1] <= 1'b1;
    b = 8'($urandom);
    host.wr(4'hD, QU_OFS_DATA, b);
    for (n = 0; n < 100 && tx[1] !== 1'b0; n++)
      @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    for (c = 0; c < 8; c++)
    begin
      repeat (16) @(posedge core_clk);
      v[c] = tx[1];
    end
    chk("tx_bits", b, v);
    repeat (32) @(posedge core_clk);
    // loopback on channel 2 with a stuck receive pin
    rx[2] <= 1'b0;
    host.wr(4'hB, QU_OFS_MCR, 8'h10);
    b = 8'($urandom);
    rxq.push_back(b);
    host.wr(4'hB, QU_OFS_DATA, b);
    lb = 1'b1;
    for (n = 0; n < 400 && rx_ready_n !== 1'b0; n++)
    begin
      @(posedge core_clk);
      lb = lb & tx[2];
    end
    chk("loop_tx", 8'h01, {7'h0, lb});
    chk("rx_ready_n", 8'h00, {7'h0, rx_ready_n});
    host.rd(4'hB, QU_OFS_DATA, v);
    chk("rx_data", rxq.pop_front(), v);
    chk("rx_ready_n", 8'h01, {7'h0, rx_ready_n});
    // auto-cts holds every holding register full; auto-rts on channel 2
    chk("tx_ready_n", 8'h00, {7'h0, tx_ready_n});
    cts_n <= 4'hF;
    host.wr(4'hB, QU_OFS_MCR, 8'h12);
    for (c = 0; c < 4; c++)
    begin
      host.wr(~(4'h1 << c), QU_OFS_EFR, 8'hC0);
      host.wr(~(4'h1 << c), QU_OFS_DATA, 8'(c));
    end
    chk("tx_ready_n", 8'h01, {7'h0, tx_ready_n});
    chk("tx", 8'h0F, {4'h0, tx});
    chk("rts_n2", 8'h00, {7'h0, rts_n[2]});
    cts_n <= 4'h0;
    repeat (4) @(posedge core_clk);
    chk("tx_ready_n", 8'h00, {7'h0, tx_ready_n});
    repeat (200) @(posedge core_clk);
    chk("rts_n2", 8'h01, {7'h0, rts_n[2]});
    // ring rising edge, modem interrupt on channel 0
    host.wr(4'hE, QU_OFS_ISTAT, 8'h0F);
    host.wr(4'hE, QU_OFS_IEN, 8'h08);
    ri_n[0] <= 1'b0;
    repeat (4) @(posedge core_clk);
    ri_n[0] <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("irq", 8'h00, {7'h0, channel_irq[0]});
    chk("irq_oe_n", 8'h01, {7'h0, channel_irq_oe_n[0]});
    irq_force_select <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("irq", 8'h01, {7'h0, channel_irq[0]});
    chk("irq_oe_n", 8'h00, {7'h0, channel_irq_oe_n[0]});
    irq_force_select <= 1'b0;
    host.wr(4'hE, QU_OFS_MCR, 8'h08);
    chk("irq", 8'h01, {7'h0, channel_irq[0]});
    chk("irq_oe_n", 8'h00, {7'h0, channel_irq_oe_n[0]});
    host.wr(4'hE, QU_OFS_ISTAT, 8'h08);
    chk("irq", 8'h00, {7'h0, channel_irq[0]});
    host.wr(4'hE, QU_OFS_MCR, 8'h00);
    chk("irq_oe_n", 8'h01, {7'h0, channel_irq_oe_n[0]});
    end_of_test();
  end
endmodule : uart_host_port_and_modem_pins_test
